// >>> tkm_regs.vh
// Constants for the touch key mode control block
// Notes on behaviour
// - Full mode: suppression straps 00 off, 01 off+fast, 10 groups, 11 global.
// - Stuck timeout straps: 00 ten seconds, 01 sixty seconds, 10 disabled, 11 reserved.
// - Detect drive strap low open-drain active low; high push-pull active high.
// - Power pin straps: 00 sync input; others low-power at 70/110/190 ms.
// - Simplified mode: one strap; low no suppression with fast, high global.
// - Simplified mode fixes 110 ms low-power, sixty second timeout, push-pull detect.
// - After reset keys are calibrated, about 260 ms, before normal reporting.
// - Straps are sampled only at power-up and then held.
// - Strap between key-6 return and key-7 sense selects simplified mode.
// - Detect output is the OR of all ten key states.
// - Change flag pulled low on any key change until host polls.
// - In sync mode each rising sync edge triggers three bursts C, A, B.
// - Sync level steady 150 ms gives free-run; next rising edge resynchronises.
// - Power request low keeps full-speed operation.
// - Power request high: low power without touch, full speed during touch.
// - Pulse high-low without touch enters low power; touch end follows level.
// - Low power skips bursts C and A for unused channel groups; burst B always runs.
// - Grouped suppression allows one active key in each of three groups.
// - Host poll byte 0x50; change released in the same cycle as the two-byte reply based 0x40.
`ifndef TKM_REGS_VH
`define TKM_REGS_VH

// ==========================================
// Clock and timing
`define TKM_CLK_HZ        40000000
`define TKM_CYC_PER_MS    (`TKM_CLK_HZ / 1000)
`define TKM_CALIB_MS      260
`define TKM_CALIB_CYC     (`TKM_CALIB_MS * `TKM_CYC_PER_MS)
`define TKM_FREE_RUN_MS   150
`define TKM_FREE_RUN_CYC  (`TKM_FREE_RUN_MS * `TKM_CYC_PER_MS)
`define TKM_LP70_MS       70
`define TKM_LP110_MS      110
`define TKM_LP190_MS      190
`define TKM_LP70_CYC      (`TKM_LP70_MS * `TKM_CYC_PER_MS)
`define TKM_LP110_CYC     (`TKM_LP110_MS * `TKM_CYC_PER_MS)
`define TKM_LP190_CYC     (`TKM_LP190_MS * `TKM_CYC_PER_MS)
`define TKM_SEC_CYC       `TKM_CLK_HZ
`define TKM_TMO_SHORT_S   10
`define TKM_TMO_LONG_S    60
`define TKM_STRAP_SETTLE  2'h3

// ==========================================
// Suppression modes
`define TKM_SUP_OFF       2'h0
`define TKM_SUP_GROUP     2'h1
`define TKM_SUP_GLOBAL    2'h2

// ==========================================
// Stuck-key timeout codes
`define TKM_TMO_10S       2'h0
`define TKM_TMO_60S       2'h1
`define TKM_TMO_OFF       2'h2
`define TKM_TMO_RSVD      2'h3

// ==========================================
// Shared pin function codes
`define TKM_PIN_SYNC      2'h0
`define TKM_PIN_LP70      2'h1
`define TKM_PIN_LP110     2'h2
`define TKM_PIN_LP190     2'h3

// ==========================================
// Bursts and key groups
`define TKM_BURST_C       2'h0
`define TKM_BURST_A       2'h1
`define TKM_BURST_B       2'h2
`define TKM_KEYS_C        10'h300
`define TKM_KEYS_A        10'h033
`define TKM_KEYS_B        10'h0CC
`define TKM_GRP0          10'h033
`define TKM_GRP1          10'h0CC
`define TKM_GRP2          10'h300

// ==========================================
// Serial reply
`define TKM_POLL_BYTE     8'h50
`define TKM_REPLY_BASE    8'h40

`endif

// >>> tkm_key_suppress.v
// Key suppression filter: off, grouped or global
`include "tkm_regs.vh"

module tkm_key_suppress (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       sys_rst,
  // Mode and keys
  input  wire [1:0] sup_mode,
  input  wire [9:0] keys_in,
  output reg  [9:0] keys_out
);

  // Keep the held key while touched, else lowest touched key
  function [9:0] keep_one;
    input [9:0] req;
    input [9:0] held;
    begin
      if ((req & held) != 10'h000)
        keep_one = req & held;
      else
        keep_one = req & (~req + 10'h001);
    end
  endfunction

  reg [9:0] next_keys;

  always @* begin
    case (sup_mode)
      `TKM_SUP_GROUP: begin
        next_keys = keep_one(keys_in & `TKM_GRP0, keys_out & `TKM_GRP0) |
                    keep_one(keys_in & `TKM_GRP1, keys_out & `TKM_GRP1) |
                    keep_one(keys_in & `TKM_GRP2, keys_out & `TKM_GRP2);
      end
      `TKM_SUP_GLOBAL: next_keys = keep_one(keys_in, keys_out);
      default:         next_keys = keys_in;
    endcase
  end

  always @(posedge clk_sys) begin
    if (sys_rst)
      keys_out <= 10'h000;
    else
      keys_out <= next_keys;
  end

endmodule // tkm_key_suppress

// >>> tkm_mode_control.v
// Touch key mode control: straps, detect, change flag, bursts, power
`include "tkm_regs.vh"

module tkm_mode_control #(
  parameter [25:0] CALIB_CYC    = `TKM_CALIB_CYC,
  parameter [25:0] FREE_RUN_CYC = `TKM_FREE_RUN_CYC,
  parameter [25:0] LP70_CYC     = `TKM_LP70_CYC,
  parameter [25:0] LP110_CYC    = `TKM_LP110_CYC,
  parameter [25:0] LP190_CYC    = `TKM_LP190_CYC,
  parameter [25:0] SEC_CYC      = `TKM_SEC_CYC
) (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       sys_rst,
  // Option straps (pins)
  input  wire       suppress_sel0,
  input  wire       suppress_sel1,
  input  wire       stuck_timeout_sel0,
  input  wire       stuck_timeout_sel1,
  input  wire       detect_drive_strap,
  input  wire       power_pin_func_sel0,
  input  wire       power_pin_func_sel1,
  input  wire       simplified_select_strap,
  // Shared sync or power request pin
  input  wire       burst_trigger_or_power_req,
  // Acquisition side
  input  wire [9:0] key_state,
  input  wire [9:0] key_used,
  input  wire       burst_done,
  output reg        burst_req,
  output reg  [1:0] burst_sel,
  output reg        cycle_end,
  output reg  [9:0] key_recal,
  // Serial side
  input  wire       host_poll,
  output reg        reply_valid,
  output reg  [7:0] reply_byte0,
  output reg  [7:0] reply_byte1,
  // Pins
  output wire       detect_out,
  output wire       detect_oe,
  output wire       change_out,
  output wire       change_oe,
  // Status
  output reg        keys_ready,
  output reg        low_power,
  output reg        free_run,
  output reg        cfg_valid,
  output reg        simplified_mode,
  output reg  [1:0] sup_mode,
  output reg        fast_detect,
  output reg  [1:0] timeout_code,
  output reg  [1:0] pin_func,
  output reg        detect_push_pull,
  output wire [9:0] reported_keys
);

  // ==========================================
  // Pin synchronisers
  reg [8:0] pin_meta;
  reg [8:0] pin_sync;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_meta <= 9'h000;
      pin_sync <= 9'h000;
    end else begin
      pin_meta <= {burst_trigger_or_power_req, simplified_select_strap, power_pin_func_sel1,
                   power_pin_func_sel0, detect_drive_strap, stuck_timeout_sel1,
                   stuck_timeout_sel0, suppress_sel1, suppress_sel0};
      pin_sync <= pin_meta;
    end
  end

  wire req_lvl = pin_sync[8];

  // ==========================================
  // Strap capture and decode, once per reset
  reg [1:0] settle;
  reg [7:0] straps;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      settle    <= 2'h0;
      straps    <= 8'h00;
      cfg_valid <= 1'b0;
    end else if (!cfg_valid) begin
      if (settle == `TKM_STRAP_SETTLE) begin
        straps    <= pin_sync[7:0];
        cfg_valid <= 1'b1;
      end else begin
        settle <= settle + 2'h1;
      end
    end
  end

  always @* begin
    simplified_mode = straps[7];
    if (straps[7]) begin
      sup_mode         = straps[0] ? `TKM_SUP_GLOBAL : `TKM_SUP_OFF;
      fast_detect      = ~straps[0];
      timeout_code     = `TKM_TMO_60S;
      pin_func         = `TKM_PIN_LP110;
      detect_push_pull = 1'b1;
    end else begin
      case (straps[1:0])
        2'h0:    sup_mode = `TKM_SUP_OFF;
        2'h1:    sup_mode = `TKM_SUP_OFF;
        2'h2:    sup_mode = `TKM_SUP_GROUP;
        default: sup_mode = `TKM_SUP_GLOBAL;
      endcase
      fast_detect      = (straps[1:0] == 2'h1);
      timeout_code     = straps[3:2];
      pin_func         = straps[6:5];
      detect_push_pull = straps[4];
    end
  end

  wire sync_mode = (pin_func == `TKM_PIN_SYNC);

  // ==========================================
  // Calibration wait
  reg [25:0] calib_cnt;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      calib_cnt  <= 26'h0000000;
      keys_ready <= 1'b0;
    end else if (!keys_ready) begin
      if (calib_cnt >= CALIB_CYC - 26'h1)
        keys_ready <= 1'b1;
      else
        calib_cnt <= calib_cnt + 26'h1;
    end
  end

  wire [9:0] live_keys = keys_ready ? (key_state & key_used) : 10'h000;

  // ==========================================
  // Suppression, detect and change flag
  tkm_key_suppress u_sup (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .sup_mode (sup_mode),
    .keys_in  (live_keys),
    .keys_out (reported_keys)
  );

  wire any_key = |reported_keys;
  reg  [9:0] last_keys;
  reg        change_flag;

  assign detect_out = detect_push_pull ? any_key : 1'b0;
  assign detect_oe  = detect_push_pull ? 1'b1 : any_key;
  assign change_out = 1'b0;
  assign change_oe  = change_flag;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      last_keys   <= 10'h000;
      change_flag <= 1'b0;
      reply_valid <= 1'b0;
      reply_byte0 <= `TKM_REPLY_BASE;
      reply_byte1 <= `TKM_REPLY_BASE;
    end else begin
      reply_valid <= host_poll;
      if (host_poll) begin
        reply_byte0 <= `TKM_REPLY_BASE | {2'h0, reported_keys[5:0]};
        reply_byte1 <= `TKM_REPLY_BASE | {4'h0, reported_keys[9:6]};
      end
      if (cycle_end && reported_keys != last_keys) begin
        change_flag <= 1'b1;
        last_keys   <= reported_keys;
      end else if (host_poll) begin
        change_flag <= 1'b0;
      end
    end
  end

  // ==========================================
  // Sync edge and free-run detection
  reg        req_prev;
  reg [25:0] steady_cnt;
  reg        sync_pend;
  // No edge before capture: pin_sync leaves reset low even if the pin idles high
  wire       sync_rise = req_lvl & ~req_prev & cfg_valid;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      req_prev   <= 1'b0;
      steady_cnt <= 26'h0000000;
      free_run   <= 1'b0;
      sync_pend  <= 1'b0;
    end else begin
      req_prev <= req_lvl;
      if (req_lvl != req_prev)
        steady_cnt <= 26'h0000000;
      else if (steady_cnt < FREE_RUN_CYC)
        steady_cnt <= steady_cnt + 26'h1;
      if (sync_rise)
        free_run <= 1'b0;
      else if (steady_cnt >= FREE_RUN_CYC - 26'h1)
        free_run <= 1'b1;
      if (sync_rise && sync_mode)
        sync_pend <= 1'b1;
      else if (burst_req)
        sync_pend <= 1'b0;
    end
  end

  // ==========================================
  // Power mode
  reg touch_prev;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      touch_prev <= 1'b0;
      low_power  <= 1'b0;
    end else begin
      touch_prev <= any_key;
      if (sync_mode || any_key)
        low_power <= 1'b0;
      else if (touch_prev)
        low_power <= req_lvl;
      else if (req_lvl)
        low_power <= 1'b1;
    end
  end

  // ==========================================
  // Burst sequencer
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_BURST = 3'b010;
  localparam [2:0] ST_GAP   = 3'b100;

  reg  [2:0]  state;
  reg  [25:0] gap_cnt;
  wire need_c = ~low_power | (|(key_used & `TKM_KEYS_C));
  wire need_a = ~low_power | (|(key_used & `TKM_KEYS_A));
  wire [1:0] first_burst = need_c ? `TKM_BURST_C : (need_a ? `TKM_BURST_A : `TKM_BURST_B);
  wire start = sync_mode ? (sync_pend | free_run) : 1'b1;
  reg  [25:0] gap_len;

  always @* begin
    case (pin_func)
      `TKM_PIN_LP70:  gap_len = LP70_CYC;
      `TKM_PIN_LP190: gap_len = LP190_CYC;
      default:        gap_len = LP110_CYC;
    endcase
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state     <= ST_IDLE;
      burst_req <= 1'b0;
      burst_sel <= `TKM_BURST_C;
      cycle_end <= 1'b0;
      gap_cnt   <= 26'h0000000;
    end else begin
      burst_req <= 1'b0;
      cycle_end <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (cfg_valid && start) begin
            burst_sel <= first_burst;
            burst_req <= 1'b1;
            state     <= ST_BURST;
          end
        end
        ST_BURST: begin
          if (burst_done) begin
            if (burst_sel == `TKM_BURST_C) begin
              burst_sel <= need_a ? `TKM_BURST_A : `TKM_BURST_B;
              burst_req <= 1'b1;
            end else if (burst_sel == `TKM_BURST_A) begin
              burst_sel <= `TKM_BURST_B;
              burst_req <= 1'b1;
            end else begin
              cycle_end <= 1'b1;
              gap_cnt   <= 26'h0000000;
              state     <= (low_power && !sync_mode) ? ST_GAP : ST_IDLE;
            end
          end
        end
        ST_GAP: begin
          if (!low_power || gap_cnt >= gap_len - 26'h1)
            state <= ST_IDLE;
          else
            gap_cnt <= gap_cnt + 26'h1;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // Stuck-key timeout
  reg [25:0] sec_cnt;
  reg        sec_tick;
  reg [5:0]  on_secs [0:9];
  wire [5:0] tmo_limit = (timeout_code == `TKM_TMO_10S) ? 6'd`TKM_TMO_SHORT_S : 6'd`TKM_TMO_LONG_S;
  wire       tmo_on = (timeout_code == `TKM_TMO_10S) || (timeout_code == `TKM_TMO_60S);
  integer    k;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      sec_cnt   <= 26'h0000000;
      sec_tick  <= 1'b0;
      key_recal <= 10'h000;
      for (k = 0; k < 10; k = k + 1)
        on_secs[k] <= 6'h00;
    end else begin
      sec_tick <= (sec_cnt >= SEC_CYC - 26'h1);
      sec_cnt  <= (sec_cnt >= SEC_CYC - 26'h1) ? 26'h0000000 : sec_cnt + 26'h1;
      for (k = 0; k < 10; k = k + 1) begin
        key_recal[k] <= 1'b0;
        if (!live_keys[k] || !tmo_on) begin
          on_secs[k] <= 6'h00;
        end else if (sec_tick) begin
          // First tick may come early, so one more keeps the hold at full length
          if (on_secs[k] >= tmo_limit) begin
            on_secs[k]   <= 6'h00;
            key_recal[k] <= 1'b1;
          end else begin
            on_secs[k] <= on_secs[k] + 6'h01;
          end
        end
      end
    end
  end

endmodule // tkm_mode_control

// >>> tkm_mode_props.sv
// Port assertions for the touch key mode control block
module tkm_mode_props (
  // Clock and reset
  input logic       clk_sys,
  input logic       sys_rst,
  // Serial side
  input logic       host_poll,
  input logic       reply_valid,
  input logic [7:0] reply_byte0,
  input logic [7:0] reply_byte1,
  // Pins and status
  input logic       cycle_end,
  input logic [1:0] burst_sel,
  input logic       detect_out,
  input logic       detect_oe,
  input logic       change_out,
  input logic       change_oe,
  input logic       keys_ready,
  input logic       cfg_valid,
  input logic       simplified_mode,
  input logic [1:0] sup_mode,
  input logic       fast_detect,
  input logic [1:0] timeout_code,
  input logic [1:0] pin_func,
  input logic       detect_push_pull,
  input logic [9:0] reported_keys
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] keys_q;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // ==========================================
  // Keys as seen at the poll edge
  always_ff @(posedge clk_sys) keys_q <= reported_keys;
  // ==========================================
  // Assertions
  cfg_hold_a: assert property (cfg_valid |=> cfg_valid && $stable({simplified_mode, sup_mode, fast_detect,
    timeout_code, pin_func, detect_push_pull})) else $error("Configuration moved after capture");
  fast_only_a: assert property (fast_detect |-> sup_mode == 2'h0)
    else $error("Fast detect with suppression");
  simp_fix_a: assert property (simplified_mode |-> pin_func == 2'h2 && timeout_code == 2'h1 && detect_push_pull
    && sup_mode != 2'h1) else $error("Simplified options wrong");
  calib_mask_a: assert property (!keys_ready |-> reported_keys == 10'h000)
    else $error("Keys reported during calibration");
  det_pp_a: assert property (detect_push_pull |-> detect_oe && detect_out == (|reported_keys))
    else $error("Push-pull detect wrong");
  det_od_a: assert property (!detect_push_pull |-> !detect_out && detect_oe == (|reported_keys))
    else $error("Open-drain detect wrong");
  change_clr_a: assert property (change_oe && host_poll && !cycle_end |=> !change_oe && !change_out)
    else $error("Change flag not released by poll");
  reply_a: assert property (host_poll |=> reply_valid && reply_byte0 == {2'b01, keys_q[5:0]}
    && reply_byte1 == {4'h4, keys_q[9:6]}) else $error("Reply bytes wrong");
  grp_one_a: assert property (sup_mode == 2'h1 |-> $countones(reported_keys & 10'h033) <= 1
    && $countones(reported_keys & 10'h0CC) <= 1 && $countones(reported_keys & 10'h300) <= 1)
    else $error("Two keys in one group");
  glob_one_a: assert property (sup_mode == 2'h2 |-> $countones(reported_keys) <= 1)
    else $error("Two keys under global suppression");
  cyc_last_a: assert property (cycle_end |-> burst_sel == 2'h2)
    else $error("Cycle did not end on burst B");
endmodule // tkm_mode_props

// >>> tkm_host_model.sv
// Far side model: shared pin driver and acquisition burst responder
module tkm_host_model #(
  parameter int HOLD_CYC = 6000
) (
  // Clock
  input  logic       clk_sys,
  // Bench controls
  input  logic       pin_cmd,
  input  logic [3:0] burst_lat,
  // Block side
  input  logic       burst_req,
  output logic       pin,
  output logic       burst_done
);
  timeunit 1ns;
  timeprecision 100ps;
  int hold_cnt = 0;
  int lat_cnt = -1;
  initial begin
    pin = 1'b0;
    burst_done = 1'b0;
  end
  // ==========================================
  // Each pin level kept at least HOLD_CYC cycles
  always @(posedge clk_sys) begin
    if (hold_cnt < HOLD_CYC) begin
      hold_cnt <= hold_cnt + 1;
    end else if (pin !== pin_cmd) begin
      pin <= pin_cmd;
      hold_cnt <= 0;
    end
  end
  // ==========================================
  // Burst answered burst_lat + 2 cycles after request rises
  always @(posedge clk_sys) begin
    burst_done <= (lat_cnt == 0);
    if (burst_req) begin
      lat_cnt <= burst_lat;
    end else if (lat_cnt >= 0) begin
      lat_cnt <= lat_cnt - 1;
    end
  end
endmodule // tkm_host_model

// >>> testbench.sv
// Self-checking testbench for the touch key mode control block
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CAL = 50;
  localparam int SEC = 16;
  localparam int FREE = 100;
  localparam int LP70 = 20;
  localparam int LP110 = 30;
  localparam int LP190 = 40;
  localparam int HOLD = 4;
  logic       clk_sys = 1'b0;
  logic       sys_rst = 1'b1;
  logic       host_poll = 1'b0;
  logic       pin_cmd = 1'b0;
  logic [7:0] st = 8'h00;
  logic [9:0] key_state = 10'h000;
  logic [9:0] key_used = 10'h3FF;
  logic [3:0] lat = 4'h2;
  logic       pin, burst_done, burst_req, cycle_end, reply_valid, detect_out, detect_oe, change_out, change_oe;
  logic       keys_ready, low_power, free_run, cfg_valid, simplified_mode, fast_detect, detect_push_pull;
  logic [1:0] burst_sel, sup_mode, timeout_code, pin_func;
  logic [7:0] reply_byte0, reply_byte1;
  logic [9:0] key_recal, reported_keys;
  logic [2:0] seen;
  logic [5:0] seq;
  int         nb;
  int         miscompares = 0;
  int         n_checks = 0;
  wire  [9:0] cfg = {cfg_valid, simplified_mode, sup_mode, fast_detect, timeout_code, pin_func, detect_push_pull};

  tkm_mode_control #(.CALIB_CYC(26'(CAL)), .FREE_RUN_CYC(26'(FREE)), .LP70_CYC(26'(LP70)),
    .LP110_CYC(26'(LP110)), .LP190_CYC(26'(LP190)), .SEC_CYC(26'(SEC))) i_dut (
    .clk_sys, .sys_rst, .suppress_sel0(st[0]), .suppress_sel1(st[1]), .stuck_timeout_sel0(st[2]),
    .stuck_timeout_sel1(st[3]), .detect_drive_strap(st[4]), .power_pin_func_sel0(st[5]),
    .power_pin_func_sel1(st[6]), .simplified_select_strap(st[7]), .burst_trigger_or_power_req(pin),
    .key_state, .key_used, .burst_done, .burst_req, .burst_sel, .cycle_end, .key_recal, .host_poll,
    .reply_valid, .reply_byte0, .reply_byte1, .detect_out, .detect_oe, .change_out, .change_oe,
    .keys_ready, .low_power, .free_run, .cfg_valid, .simplified_mode, .sup_mode, .fast_detect,
    .timeout_code, .pin_func, .detect_push_pull, .reported_keys);
  tkm_host_model #(.HOLD_CYC(HOLD)) i_host (.clk_sys, .pin_cmd, .burst_lat(lat), .burst_req, .pin, .burst_done);

  always #12.5 clk_sys = ~clk_sys;
  // ==========================================
  // Shared tasks
  task automatic chk(input string what, input logic [19:0] got, input logic [19:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d, miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic restart(input logic [7:0] s);
    int n;
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    st <= s;
    key_state <= 10'h000;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (n = 0; n < CAL + 20 && keys_ready !== 1'b1; n++) @(negedge clk_sys);
    chk("calibration wait", n >= CAL && n < CAL + 12, 1'b1);
  endtask
  task automatic bursts(input int n);
    nb = 0;
    seen = 3'h0;
    seq = 6'h00;
    repeat (n) begin
      @(negedge clk_sys);
      if (burst_req === 1'b1) begin
        nb++;
        seen[burst_sel] = 1'b1;
        seq = {seq[3:0], burst_sel};
      end
    end
  endtask
  task automatic pin_to(input logic v);
    @(posedge clk_sys);
    pin_cmd <= v;
    for (int n = 0; n < 20 && pin !== v; n++) @(negedge clk_sys);
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic keys_to(input logic [9:0] k);
    @(posedge clk_sys);
    key_state <= k;
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic poll(input logic [15:0] exp);
    @(posedge clk_sys);
    host_poll <= 1'b1;
    @(posedge clk_sys);
    host_poll <= 1'b0;
    @(negedge clk_sys);
    chk("reply", {reply_valid, change_oe, reply_byte1, reply_byte0}, {2'b10, exp});
  endtask
  // ==========================================
  // Scenarios
  task automatic t_straps;
    logic [1:0] k;
    logic [9:0] exp;
    for (int i = 0; i < 6; i++) begin
      k = i[1:0];
      if (i < 4) begin
        restart({1'b0, k, k[0], k, k});
        exp = {2'b10, k[1] ? (k[0] ? 2'h2 : 2'h1) : 2'h0, k == 2'h1, k, k, k[0]};
      end else begin
        restart({7'h7F, k[0]});
        exp = {2'b11, k[0] ? 2'h2 : 2'h0, !k[0], 2'h1, 2'h2, 1'b1};
      end
      chk("strap decode", cfg, exp);
      @(posedge clk_sys);
      st <= ~st;
      repeat (8) @(negedge clk_sys);
      chk("held decode", cfg, exp);
    end
  endtask
  task automatic t_sync;
    restart(8'h00);
    @(posedge clk_sys);
    pin_cmd <= 1'b1;
    bursts(40);
    chk("sync bursts", {nb[3:0], seq}, {4'h3, 6'h06});
    for (int n = 0; n < 200 && free_run !== 1'b1; n++) @(negedge clk_sys);
    bursts(60);
    chk("free run", {free_run, nb >= 6}, 2'b11);
    pin_to(1'b0);
    pin_to(1'b1);
    chk("resync", free_run, 1'b0);
  endtask
  task automatic t_change;
    keys_to(10'h085);
    for (int n = 0; n < 200 && change_oe !== 1'b1; n++) @(negedge clk_sys);
    chk("change on touch", change_oe, 1'b1);
    poll(16'h4245);
    bursts(120);
    chk("change quiet", {change_oe, nb > 0}, 2'b01);
    keys_to(10'h000);
    for (int n = 0; n < 200 && change_oe !== 1'b1; n++) @(negedge clk_sys);
    chk("change on release", change_oe, 1'b1);
    poll(16'h4040);
  endtask
  task automatic t_suppress;
    logic [23:0] s = 24'h810302;
    for (int i = 0; i < 3; i++) begin
      restart(s[8*i +: 8]);
      keys_to(10'h3FF);
      chk("group counts", i ? 12'($countones(reported_keys)) : {4'($countones(reported_keys & 10'h033)),
        4'($countones(reported_keys & 10'h0CC)), 4'($countones(reported_keys & 10'h300))},
        i ? 12'h001 : 12'h111);
    end
  endtask
  task automatic t_power;
    logic [29:0] used = {10'h3FF, 10'h0FF, 10'h0CC};
    pin_to(1'b0);
    @(posedge clk_sys);
    key_used <= 10'h0CC;
    lat <= 4'h9;
    restart(8'h20);
    repeat (60) @(negedge clk_sys);
    chk("full speed", low_power, 1'b0);
    pin_to(1'b1);
    for (int n = 0; n < 40 && low_power !== 1'b1; n++) @(negedge clk_sys);
    chk("low power", low_power, 1'b1);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      key_used <= used[10*i +: 10];
      bursts(150);
      chk("burst set", seen, i == 0 ? 3'h4 : (i == 1 ? 3'h6 : 3'h7));
    end
    keys_to(10'h004);
    chk("touch speed", low_power, 1'b0);
    pin_to(1'b0);
    keys_to(10'h000);
    repeat (40) @(negedge clk_sys);
    chk("end with pin low", low_power, 1'b0);
    pin_to(1'b1);
    pin_to(1'b0);
    repeat (40) @(negedge clk_sys);
    chk("after pulse", low_power, 1'b1);
    @(posedge clk_sys);
    lat <= 4'h2;
  endtask
  task automatic t_stuck;
    int n;
    int t;
    for (int i = 0; i < 2; i++) begin
      restart({4'h0, i[0], 3'h0});
      t = i ? 1100 : 10 * SEC;
      keys_to(10'h001);
      for (n = 4; n < 1100 && key_recal === 10'h000; n++) @(negedge clk_sys);
      chk("recal time", {n >= t && n <= t + SEC, key_recal}, {1'b1, i ? 10'h000 : 10'h001});
    end
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_straps();
    t_sync();
    t_change();
    t_suppress();
    t_power();
    t_stuck();
    stop_test();
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    miscompares++;
    stop_test();
  end
endmodule // testbench

bind tkm_mode_control tkm_mode_props i_props (.clk_sys, .sys_rst, .host_poll, .reply_valid, .reply_byte0,
  .reply_byte1, .cycle_end, .burst_sel, .detect_out, .detect_oe, .change_out, .change_oe, .keys_ready,
  .cfg_valid, .simplified_mode, .sup_mode, .fast_detect, .timeout_code, .pin_func, .detect_push_pull,
  .reported_keys);
